// ===== hdl/boundary_scan_tap.sv
// Test access port controller with instruction, bypass and id registers.
`timescale 1ns/1ps
module boundary_scan_tap
   import tap_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic test_clock,
   input wire logic test_mode_select,
   input wire logic test_data_in,
   input wire logic test_reset_n,
   input wire logic [PIN_IN_COUNT-1:0] pin_in,
   input wire logic [PIN_OUT_COUNT-1:0] core_out,
   input wire logic [PIN_OUT_COUNT-1:0] core_out_en,
   output logic test_data_out,
   output logic test_data_out_en,
   output logic [PIN_OUT_COUNT-1:0] pin_out,
   output logic [PIN_OUT_COUNT-1:0] pin_out_en
);

   // Every register of the port except the boundary-scan chain lives in this one image.
   typedef struct packed {
      logic tck_meta;
      logic tck_sync;
      logic tck_prev;
      logic tms_meta;
      logic tms_sync;
      logic tdi_meta;
      logic tdi_sync;
      logic trst_meta;
      logic trst_sync;
      logic [PIN_IN_COUNT-1:0] pin_meta;
      logic [PIN_IN_COUNT-1:0] pin_sync;
      tap_state_type state;
      logic [IR_WIDTH-1:0] ir_shift;
      logic [IR_WIDTH-1:0] ir;
      logic bypass;
      logic [ID_WIDTH-1:0] id_shift;
      logic [ID_WIDTH-1:0] id_latch;
      logic tdo;
      logic tdo_en;
      logic [PIN_OUT_COUNT-1:0] pin_out;
      logic [PIN_OUT_COUNT-1:0] pin_out_en;
   } tap_regs_type;

   // Samplers start at the idle pin levels with test reset sampled low, so no false edge follows reset.
   localparam tap_regs_type TAP_REGS_RESET = '{
      tck_meta: 1'h0,
      tck_sync: 1'h0,
      tck_prev: 1'h0,
      tms_meta: 1'h1,
      tms_sync: 1'h1,
      tdi_meta: 1'h1,
      tdi_sync: 1'h1,
      trst_meta: 1'h0,
      trst_sync: 1'h0,
      pin_meta: 4'h0,
      pin_sync: 4'h0,
      state: TEST_LOGIC_RESET,
      ir_shift: IR_CAPTURE_VALUE,
      ir: INSTR_IDCODE,
      bypass: BYPASS_CAPTURE_VALUE,
      id_shift: ID_VALUE,
      id_latch: ID_VALUE,
      tdo: 1'h0,
      tdo_en: 1'h0,
      pin_out: 4'h0,
      pin_out_en: 4'h0
   };

   // Current and next image of the port registers.
   tap_regs_type r;
   tap_regs_type next_r;

   // Edge strobes, instruction selects and boundary-scan hook-up.
   logic tck_rise;
   logic tck_fall;
   logic sel_bsr;
   logic sel_id;
   logic sel_bypass;
   logic bsr_capture;
   logic bsr_shift;
   logic bsr_update;
   logic bsr_serial_out;
   logic [BSR_LEN-1:0] bsr_capture_data;
   logic [BSR_LEN-1:0] bsr_parallel;
   logic [PIN_OUT_COUNT-1:0] bsr_out;
   logic [PIN_OUT_COUNT-1:0] bsr_oe;

   // Next controller state for one rising edge of the test clock.
   function automatic tap_state_type tap_next(input tap_state_type s,
                                              input logic tms);
      tap_state_type n;
      n = s;
      case (s)
         TEST_LOGIC_RESET: begin
            n = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
         end
         RUN_TEST_IDLE: begin
            n = tms ? SELECT_DR_SCAN : RUN_TEST_IDLE;
         end
         SELECT_DR_SCAN: begin
            n = tms ? SELECT_IR_SCAN : CAPTURE_DR;
         end
         CAPTURE_DR: begin
            n = tms ? EXIT1_DR : SHIFT_DR;
         end
         SHIFT_DR: begin
            n = tms ? EXIT1_DR : SHIFT_DR;
         end
         EXIT1_DR: begin
            n = tms ? UPDATE_DR : PAUSE_DR;
         end
         PAUSE_DR: begin
            n = tms ? EXIT2_DR : PAUSE_DR;
         end
         EXIT2_DR: begin
            n = tms ? UPDATE_DR : SHIFT_DR;
         end
         UPDATE_DR: begin
            n = tms ? SELECT_DR_SCAN : RUN_TEST_IDLE;
         end
         SELECT_IR_SCAN: begin
            n = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
         end
         CAPTURE_IR: begin
            n = tms ? EXIT1_IR : SHIFT_IR;
         end
         SHIFT_IR: begin
            n = tms ? EXIT1_IR : SHIFT_IR;
         end
         EXIT1_IR: begin
            n = tms ? UPDATE_IR : PAUSE_IR;
         end
         PAUSE_IR: begin
            n = tms ? EXIT2_IR : PAUSE_IR;
         end
         EXIT2_IR: begin
            n = tms ? UPDATE_IR : SHIFT_IR;
         end
         UPDATE_IR: begin
            n = tms ? SELECT_DR_SCAN : RUN_TEST_IDLE;
         end
         default: begin
            n = TEST_LOGIC_RESET;
         end
      endcase
      return n;
   endfunction

   // Edges of the sampled test clock; the reset pin gates every action.
   assign tck_rise = r.tck_sync & ~r.tck_prev & r.trst_sync;
   assign tck_fall = ~r.tck_sync & r.tck_prev & r.trst_sync;

   // Instruction decode; unknown codes fall back to the bypass register.
   assign sel_bsr = (r.ir == INSTR_EXTEST) || (r.ir == INSTR_SAMPLE);
   assign sel_id = (r.ir == INSTR_IDCODE);
   assign sel_bypass = ~sel_bsr & ~sel_id;

   // The boundary-scan chain acts only while its instruction is current.
   assign bsr_capture = tck_rise && (r.state == CAPTURE_DR) && sel_bsr;
   assign bsr_shift = tck_rise && (r.state == SHIFT_DR) && sel_bsr;
   assign bsr_update = tck_fall && (r.state == UPDATE_DR) && sel_bsr;

   // Capture takes the input pins and the core's output drive.
   assign bsr_capture_data = {core_out_en, core_out, r.pin_sync};

   // Output data and enable fields of the boundary-scan latch.
   assign bsr_out = bsr_parallel[BSR_OUT_LSB +: PIN_OUT_COUNT];
   assign bsr_oe = bsr_parallel[BSR_OE_LSB +: PIN_OUT_COUNT];

   // The boundary-scan register shifts from the sampled serial input.
   boundary_scan_register bsr_inst (
      .clk(clk),
      .rstn(rstn),
      .capture_en(bsr_capture),
      .shift_en(bsr_shift),
      .update_en(bsr_update),
      .serial_in(r.tdi_sync),
      .capture_data(bsr_capture_data),
      .serial_out(bsr_serial_out),
      .parallel(bsr_parallel)
   );

   always_comb begin
      next_r = r;

      // Two-stage synchronisers for every pin from outside the clock domain.
      next_r.tck_meta = test_clock;
      next_r.tck_sync = r.tck_meta;
      next_r.tck_prev = r.tck_sync;
      next_r.tms_meta = test_mode_select;
      next_r.tms_sync = r.tms_meta;
      next_r.tdi_meta = test_data_in;
      next_r.tdi_sync = r.tdi_meta;
      next_r.trst_meta = test_reset_n;
      next_r.trst_sync = r.trst_meta;
      next_r.pin_meta = pin_in;
      next_r.pin_sync = r.pin_meta;

      // A low test reset holds the controller in Test-Logic-Reset.
      if (!r.trst_sync) begin
         next_r.state = TEST_LOGIC_RESET;
      end else if (tck_rise) begin
         next_r.state = tap_next(r.state, r.tms_sync);
      end

      // Register actions on the rising edge of the test clock.
      if (tck_rise) begin
         case (r.state)
            CAPTURE_DR: begin
               if (sel_id) begin
                  next_r.id_shift = r.id_latch;
               end else if (sel_bypass) begin
                  next_r.bypass = BYPASS_CAPTURE_VALUE;
               end
            end
            SHIFT_DR: begin
               if (sel_id) begin
                  next_r.id_shift = {r.tdi_sync,
                                     r.id_shift[ID_WIDTH-1:1]};
               end else if (sel_bypass) begin
                  next_r.bypass = r.tdi_sync;
               end
            end
            CAPTURE_IR: begin
               next_r.ir_shift = IR_CAPTURE_VALUE;
            end
            SHIFT_IR: begin
               next_r.ir_shift = {r.tdi_sync,
                                  r.ir_shift[IR_WIDTH-1:1]};
            end
            default: begin
               next_r.ir_shift = r.ir_shift;
            end
         endcase
      end

      // Latch updates and output data changes on the falling edge.
      if (tck_fall) begin
         case (r.state)
            UPDATE_IR: begin
               next_r.ir = r.ir_shift;
            end
            UPDATE_DR: begin
               next_r.id_latch = ID_VALUE;
            end
            default: begin
               next_r.ir = r.ir;
            end
         endcase
         case (r.state)
            SHIFT_IR: begin
               next_r.tdo = r.ir_shift[0];
               next_r.tdo_en = 1'h1;
            end
            SHIFT_DR: begin
               if (sel_bsr) begin
                  next_r.tdo = bsr_serial_out;
               end else if (sel_id) begin
                  next_r.tdo = r.id_shift[0];
               end else begin
                  next_r.tdo = r.bypass;
               end
               next_r.tdo_en = 1'h1;
            end
            default: begin
               next_r.tdo_en = 1'h0;
            end
         endcase
      end

      // The reset state forces the identification instruction.
      if (next_r.state == TEST_LOGIC_RESET) begin
         next_r.ir = INSTR_IDCODE;
      end
      if (!r.trst_sync) begin
         next_r.tdo_en = 1'h0;
      end

      // Output pins follow the core unless the instruction takes them.
      case (r.ir)
         INSTR_EXTEST: begin
            next_r.pin_out = bsr_out;
            next_r.pin_out_en = bsr_oe;
         end
         INSTR_CLAMP: begin
            next_r.pin_out = bsr_out;
            next_r.pin_out_en = bsr_oe;
         end
         INSTR_HIGHZ: begin
            next_r.pin_out = core_out;
            next_r.pin_out_en = 4'h0;
         end
         default: begin
            next_r.pin_out = core_out;
            next_r.pin_out_en = core_out_en;
         end
      endcase
   end

   // Reset is synchronous to the system clock.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         r <= TAP_REGS_RESET;
      end else begin
         r <= next_r;
      end
   end

   // Every output comes straight from the register image.
   assign test_data_out = r.tdo;
   assign test_data_out_en = r.tdo_en;
   assign pin_out = r.pin_out;
   assign pin_out_en = r.pin_out_en;

endmodule

// ===== hdl/tap_pkg.sv
// Constants and types shared by the boundary-scan test access port.
package tap_pkg;

   localparam int IR_WIDTH = 3;
   localparam int ID_WIDTH = 32;
   localparam int PIN_IN_COUNT = 4;
   localparam int PIN_OUT_COUNT = 4;

   localparam int BSR_IN_LSB = 0;
   localparam int BSR_OUT_LSB = PIN_IN_COUNT;
   localparam int BSR_OE_LSB = PIN_IN_COUNT + PIN_OUT_COUNT;
   localparam int BSR_LEN = PIN_IN_COUNT + 2 * PIN_OUT_COUNT;

   localparam logic [IR_WIDTH-1:0] INSTR_EXTEST = 3'h0;
   localparam logic [IR_WIDTH-1:0] INSTR_IDCODE = 3'h1;
   localparam logic [IR_WIDTH-1:0] INSTR_SAMPLE = 3'h2;
   localparam logic [IR_WIDTH-1:0] INSTR_CLAMP = 3'h3;
   localparam logic [IR_WIDTH-1:0] INSTR_HIGHZ = 3'h4;
   localparam logic [IR_WIDTH-1:0] INSTR_BYPASS = 3'h7;
   localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VALUE = 3'h1;

   // Identity fields; the values are arbitrary.
   localparam logic [3:0] ID_REVISION = 4'h0;
   localparam logic [15:0] ID_PART_CODE = 16'h5A5A;
   localparam logic [10:0] ID_MAKER_CODE = 11'h155;
   localparam logic [0:0] ID_FIXED_BIT = 1'h1;
   localparam logic [ID_WIDTH-1:0] ID_VALUE =
      {ID_REVISION, ID_PART_CODE, ID_MAKER_CODE, ID_FIXED_BIT};

   localparam logic [0:0] BYPASS_CAPTURE_VALUE = 1'h0;
   localparam logic [BSR_LEN-1:0] BSR_RESET_VALUE = 12'h000;

   typedef enum logic [3:0] {
      TEST_LOGIC_RESET,
      RUN_TEST_IDLE,
      SELECT_DR_SCAN,
      CAPTURE_DR,
      SHIFT_DR,
      EXIT1_DR,
      PAUSE_DR,
      EXIT2_DR,
      UPDATE_DR,
      SELECT_IR_SCAN,
      CAPTURE_IR,
      SHIFT_IR,
      EXIT1_IR,
      PAUSE_IR,
      EXIT2_IR,
      UPDATE_IR
   } tap_state_type;

endpackage

// ===== hdl/boundary_scan_register.sv
// Boundary-scan register with a shift path and a latched parallel output.
`timescale 1ns/1ps
module boundary_scan_register
   import tap_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic capture_en,
   input wire logic shift_en,
   input wire logic update_en,
   input wire logic serial_in,
   input wire logic [BSR_LEN-1:0] capture_data,
   output logic serial_out,
   output logic [BSR_LEN-1:0] parallel
);

   typedef struct packed {
      logic [BSR_LEN-1:0] shift;
      logic [BSR_LEN-1:0] latch;
   } bsr_state_type;

   bsr_state_type r;
   bsr_state_type next_r;

   always_comb begin
      next_r = r;
      if (capture_en) begin
         next_r.shift = capture_data;
      end else if (shift_en) begin
         next_r.shift = {serial_in, r.shift[BSR_LEN-1:1]};
      end
      if (update_en) begin
         next_r.latch = r.shift;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         r <= {BSR_RESET_VALUE, BSR_RESET_VALUE};
      end else begin
         r <= next_r;
      end
   end

   assign serial_out = r.shift[0];
   assign parallel = r.latch;

endmodule

// ===== test/boundary_scan_tap_props.sv
// Port-level checks of the boundary-scan test access port.
`timescale 1ns/1ps
module boundary_scan_tap_props
   import tap_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic test_clock,
   input wire logic test_mode_select,
   input wire logic test_data_in,
   input wire logic test_reset_n,
   input wire logic [PIN_IN_COUNT-1:0] pin_in,
   input wire logic [PIN_OUT_COUNT-1:0] core_out,
   input wire logic [PIN_OUT_COUNT-1:0] core_out_en,
   input wire logic test_data_out,
   input wire logic test_data_out_en,
   input wire logic [PIN_OUT_COUNT-1:0] pin_out,
   input wire logic [PIN_OUT_COUNT-1:0] pin_out_en
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_rst_quiet;
      $rose(rstn) |-> !test_data_out_en && !test_data_out && pin_out_en == 4'h0;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs not cleared by reset");

   property p_rst_follow;
      $rose(rstn) |=> pin_out == $past(core_out) &&
         pin_out_en == $past(core_out_en);
   endproperty
   a_rst_follow: assert property (p_rst_follow)
      else $error("pins do not follow core after reset");

   property p_trst_quiet;
      !test_reset_n [*5] |-> !test_data_out_en;
   endproperty
   a_trst_quiet: assert property (p_trst_quiet)
      else $error("serial out enabled in test reset");

   property p_trst_follow;
      !test_reset_n [*5] |-> pin_out == $past(core_out) &&
         pin_out_en == $past(core_out_en);
   endproperty
   a_trst_follow: assert property (p_trst_follow)
      else $error("pins do not follow core in test reset");

   property p_idle_hold;
      (test_reset_n && !test_clock) [*8] |=> $stable(test_data_out) &&
         $stable(test_data_out_en);
   endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("serial out moved without test clock");

   property p_en_trst;
      $rose(test_data_out_en) |-> test_reset_n && $past(test_reset_n, 3);
   endproperty
   a_en_trst: assert property (p_en_trst)
      else $error("shift started during test reset");

   property p_tdo_shift;
      $changed(test_data_out) |-> test_data_out_en;
   endproperty
   a_tdo_shift: assert property (p_tdo_shift)
      else $error("serial out changed outside shift");

   property p_en_width;
      $rose(test_data_out_en) |-> test_data_out_en [*8];
   endproperty
   a_en_width: assert property (p_en_width)
      else $error("shift window shorter than one test clock");
endmodule

bind boundary_scan_tap boundary_scan_tap_props chk (.clk(clk), .rstn(rstn),
   .test_clock(test_clock), .test_mode_select(test_mode_select),
   .test_data_in(test_data_in), .test_reset_n(test_reset_n),
   .pin_in(pin_in), .core_out(core_out), .core_out_en(core_out_en),
   .test_data_out(test_data_out), .test_data_out_en(test_data_out_en),
   .pin_out(pin_out), .pin_out_en(pin_out_en));

// ===== test/tap_tester.sv
// Model of the boundary-scan tester that drives the test port.
`timescale 1ns/1ps
module tap_tester (
   input wire logic clk,
   output logic test_clock,
   output logic test_mode_select,
   output logic test_data_in,
   input wire logic test_data_out
);
   initial begin
      test_clock = 1'b0;
      test_mode_select = 1'b1;
      test_data_in = 1'b0;
   end

   // One 200 ns test clock period; serial out is read just before the fall.
   task automatic tick(input logic m, input logic d, output logic o);
      test_mode_select <= m;
      test_data_in <= d;
      repeat (4) @(posedge clk);
      test_clock <= 1'b1;
      repeat (4) @(posedge clk);
      o = test_data_out;
      test_clock <= 1'b0;
   endtask

   // Five rises with mode select high reach Test-Logic-Reset.
   task automatic reset_by_mode();
      logic o;
      for (int i = 0; i < 5; i++) begin
         tick(1'b1, i[0], o);
      end
   endtask
endmodule

// ===== test/boundary_scan_tap_tb.sv
// Self-checking bench for the boundary-scan test access port.
`timescale 1ns/1ps
module boundary_scan_tap_tb;
   import tap_pkg::*;
   logic clk, rstn, test_clock, test_mode_select, test_data_in, tdo_wire;
   logic test_reset_n, test_data_out, test_data_out_en;
   logic [PIN_IN_COUNT-1:0] pin_in;
   logic [PIN_OUT_COUNT-1:0] core_out, core_out_en, pin_out, pin_out_en;
   logic [BSR_LEN-1:0] latch;
   logic [2:0] ins;
   int n_fail, n_tests, cycles;
   integer seed;

   assign tdo_wire = test_data_out_en ? test_data_out : 1'bz;

   boundary_scan_tap uut (.clk(clk), .rstn(rstn), .test_clock(test_clock),
      .test_mode_select(test_mode_select), .test_data_in(test_data_in),
      .test_reset_n(test_reset_n), .pin_in(pin_in), .core_out(core_out),
      .core_out_en(core_out_en), .test_data_out(test_data_out),
      .test_data_out_en(test_data_out_en), .pin_out(pin_out),
      .pin_out_en(pin_out_en));

   tap_tester tester (.clk(clk), .test_clock(test_clock),
      .test_mode_select(test_mode_select), .test_data_in(test_data_in),
      .test_data_out(tdo_wire));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_fail++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string w, input logic [31:0] e,
      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", w, e, g);
      end
   endtask

   function automatic int dr_len(input logic [2:0] c);
      case (c)
         INSTR_IDCODE: return ID_WIDTH;
         INSTR_EXTEST, INSTR_SAMPLE: return BSR_LEN;
         default: return 8;
      endcase
   endfunction

   function automatic logic [31:0] exp_dr(input logic [2:0] c, input int n,
      input logic [31:0] d, input logic [BSR_LEN-1:0] cap);
      case (c)
         INSTR_IDCODE: return ID_VALUE;
         INSTR_EXTEST, INSTR_SAMPLE: return 32'(cap);
         default: return {d[30:0], BYPASS_CAPTURE_VALUE} & ((32'h1 << n) - 1);
      endcase
   endfunction

   function automatic logic [7:0] exp_pin(input logic [2:0] c);
      case (c)
         INSTR_EXTEST, INSTR_CLAMP: return {latch[BSR_OE_LSB +: 4],
            latch[BSR_OUT_LSB +: 4]};
         INSTR_HIGHZ: return 8'h00;
         default: return {core_out_en, core_out};
      endcase
   endfunction

   task automatic pins(input string w);
      chk(w, 32'(exp_pin(ins)),
         32'({pin_out_en, ins == INSTR_HIGHZ ? 4'h0 : pin_out}));
   endtask

   task automatic step(input logic m);
      logic o;
      tester.tick(m, 1'($random(seed)), o);
   endtask

   task automatic scan(input logic ir, input int n, input logic [31:0] d,
      input logic pause, output logic [31:0] q);
      logic o, brk;
      q = '0;
      step(1'b1);
      if (ir) begin
         step(1'b1);
      end
      step(1'b0);
      step(1'b0);
      for (int i = 0; i < n; i++) begin
         brk = pause && i == n / 2 - 1;
         tester.tick(i == n - 1 || brk, d[i], o);
         q[i] = o;
         if (brk) begin
            step(1'b0);
            step(1'b0);
            step(1'b1);
            step(1'b0);
         end
      end
      step(1'b1);
      step(1'b0);
      repeat (6) @(posedge clk);
   endtask

   initial begin
      logic [31:0] d, q;
      logic [2:0] codes [8];
      codes = '{INSTR_SAMPLE, INSTR_EXTEST, INSTR_CLAMP, INSTR_HIGHZ,
         INSTR_BYPASS, 3'h5, INSTR_IDCODE, 3'h6};
      seed = 32'h9f4b76d5;
      n_fail = 0;
      n_tests = 0;
      cycles = 0;
      rstn = 1'b0;
      test_reset_n = 1'b1;
      {core_out_en, core_out, pin_in} = BSR_RESET_VALUE;
      latch = BSR_RESET_VALUE;
      ins = INSTR_IDCODE;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (6) @(posedge clk);
      step(1'b0);
      scan(1'b0, ID_WIDTH, '0, 1'b0, q);
      chk("id after reset", ID_VALUE, q);
      for (int p = 0; p < 2; p++) begin
         foreach (codes[k]) begin
            ins = codes[k];
            {core_out_en, core_out, pin_in} <= BSR_LEN'($random(seed));
            scan(1'b1, IR_WIDTH, 32'(ins), p[0], q);
            chk("ir capture", 32'(IR_CAPTURE_VALUE), q);
            pins("pins after ir");
            d = $random(seed);
            scan(1'b0, dr_len(ins), d, p[0], q);
            chk("dr scan", exp_dr(ins, dr_len(ins), d,
               {core_out_en, core_out, pin_in}), q);
            if (ins == INSTR_EXTEST || ins == INSTR_SAMPLE) begin
               latch = d[BSR_LEN-1:0];
            end
            pins("pins after dr");
         end
      end
      ins = INSTR_CLAMP;
      scan(1'b1, IR_WIDTH, 32'(ins), 1'b0, q);
      pins("pins under clamp");
      step(1'b1);
      step(1'b0);
      repeat (4) step(1'b0);
      chk("shift enable", 32'h1, 32'(test_data_out_en));
      test_reset_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk("enable in reset", 32'h0, 32'(test_data_out_en));
      ins = INSTR_IDCODE;
      pins("pins in test reset");
      test_reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      step(1'b0);
      scan(1'b0, ID_WIDTH, '1, 1'b0, q);
      chk("id after test reset", ID_VALUE, q);
      ins = INSTR_EXTEST;
      scan(1'b1, IR_WIDTH, 32'(ins), 1'b0, q);
      step(1'b1);
      step(1'b0);
      tester.reset_by_mode();
      step(1'b0);
      ins = INSTR_IDCODE;
      repeat (4) @(posedge clk);
      pins("pins after mode reset");
      scan(1'b0, ID_WIDTH, '0, 1'b0, q);
      chk("id after mode reset", ID_VALUE, q);
      wrap_up();
   end
endmodule
